/* File: logic/gpcn_pkg.sv */
// ****************************************************************
// Shared constants of the port and change-notify block
// ****************************************************************
package gpcn_pkg;

   // ****************************************************************
   // Register selection codes for the plain register port
   // ****************************************************************
   typedef enum logic [3:0] {
      GPCN_SEL_DIR   = 4'h0,  // pin_direction_reg
      GPCN_SEL_LAT   = 4'h1,  // output_latch_reg
      GPCN_SEL_LVL   = 4'h2,  // pin_level_reg
      GPCN_SEL_ODC   = 4'h3,  // open_drain_select_reg
      GPCN_SEL_ANLO  = 4'h4,  // analog_pin_config_lo
      GPCN_SEL_ANHI  = 4'h5,  // analog_pin_config_hi
      GPCN_SEL_CNELO = 4'h6,  // change_irq_enable_lo
      GPCN_SEL_CNEHI = 4'h7,  // change_irq_enable_hi
      GPCN_SEL_PULO  = 4'h8,  // weak_pullup_enable_lo
      GPCN_SEL_PUHI  = 4'h9   // weak_pullup_enable_hi
   } gpcn_sel_t;

   // ****************************************************************
   // Widths and reset values
   // ****************************************************************
   localparam int GPCN_DW = 16;                          // Register data width
   localparam int GPCN_CN_MAX = 30;                      // Most change-notify inputs
   localparam int GPCN_AN_MAX = 32;                      // Analog config bits, lo and hi
   localparam logic [15:0] GPCN_DIR_RST = 16'hFFFF;      // All pins input
   localparam logic [15:0] GPCN_LAT_RST = 16'h0000;      // Latch cleared
   localparam logic [15:0] GPCN_ODC_RST = 16'h0000;      // Push-pull outputs
   localparam logic [15:0] GPCN_AN_RST = 16'h0000;       // All analog pins analog
   localparam logic [15:0] GPCN_CNE_RST = 16'h0000;      // No change interrupts
   localparam logic [15:0] GPCN_PU_RST = 16'h0000;       // No pull-ups

endpackage : gpcn_pkg

/* File: logic/gpcn_port.sv */
`timescale 1ns/1ps
module gpcn_port
   import gpcn_pkg::*;
#(
   parameter int PORT_W = 16,                  // Pins in this port
   parameter logic [15:0] IMPL_MASK = 16'hFFFF, // Pins present on this variant
   parameter int AN_BASE = 0,                  // Analog config bit of pin 0
   parameter logic [15:0] AN_MASK = 16'h00FF,  // Pins that have an analog function
   parameter int CN_W = 30                     // Change-notify inputs
) (
   input wire logic clk_i,                     // Instruction clock
   input wire logic rst_i,                     // Async reset, active high
   input wire logic ce_i,                      // Clock enable, freezes state when low
   input wire logic sleep_i,                   // Device in Sleep, clocks stopped
   input wire logic wr_i,                      // Register write strobe
   input wire logic rd_i,                      // Register read strobe
   input wire logic [3:0] sel_i,               // Register select
   input wire logic [15:0] wdata_i,            // Register write data
   output logic [15:0] rdata_o,                // Register read data
   input wire logic [PORT_W-1:0] pin_in_i,     // Pin input levels
   output logic [PORT_W-1:0] pin_out_o,        // Pin output levels
   output logic [PORT_W-1:0] pin_oe_o,         // Pin output enables
   input wire logic [PORT_W-1:0] per_en_i,     // Peripheral enabled per pin
   input wire logic [PORT_W-1:0] per_drv_i,    // Peripheral actively driving per pin
   input wire logic [PORT_W-1:0] per_out_i,    // Peripheral output data per pin
   output logic [PORT_W-1:0] per_in_o,         // Pin level seen by peripherals
   output logic [GPCN_AN_MAX-1:0] an_mode_o,   // Analog mode per analog input
   input wire logic [CN_W-1:0] cn_pin_i,       // change_notify_input pin levels
   output logic [CN_W-1:0] pullup_en_o,        // Weak pull-up enables
   output logic cn_req_o,                      // Change request, one-cycle pulse
   output logic cn_wake_o                      // Sleep wake request, level
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (PORT_W < 1 || PORT_W > GPCN_DW) begin : g_bad_w
      $error("PORT_W must be 1 to 16");
   end
   if (CN_W <= GPCN_DW || CN_W > GPCN_CN_MAX) begin : g_bad_cn
      $error("CN_W must be 17 to 30");
   end
   if (AN_BASE < 0 || AN_BASE + PORT_W > GPCN_AN_MAX) begin : g_bad_an
      $error("AN_BASE out of range");
   end

   localparam int CNH = CN_W - GPCN_DW;        // Bits in the high CN registers
   localparam logic [PORT_W-1:0] IMPL = IMPL_MASK[PORT_W-1:0]; // Present pins

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [PORT_W-1:0] pin_direction_reg;       // One is input
   logic [PORT_W-1:0] output_latch_reg;        // Output latch
   logic [PORT_W-1:0] open_drain_select_reg;   // One is open drain
   logic [15:0] analog_pin_config_lo;          // Zero is analog
   logic [15:0] analog_pin_config_hi;          // Zero is analog
   logic [15:0] change_irq_enable_lo;          // CN enables 15:0
   logic [CNH-1:0] change_irq_enable_hi;       // CN enables above 15
   logic [15:0] weak_pullup_enable_lo;         // Pull-ups 15:0
   logic [CNH-1:0] weak_pullup_enable_hi;      // Pull-ups above 15
   logic [PORT_W-1:0] next_dir;
   logic [PORT_W-1:0] next_lat;
   logic [PORT_W-1:0] next_odc;
   logic [15:0] next_anlo;
   logic [15:0] next_anhi;
   logic [15:0] next_cnelo;
   logic [CNH-1:0] next_cnehi;
   logic [15:0] next_pulo;
   logic [CNH-1:0] next_puhi;
   logic [15:0] rdata;                         // Read data register
   logic [15:0] next_rdata;

   // ****************************************************************
   // Synchronisers and sampled state
   // ****************************************************************
   logic [PORT_W-1:0] pin_meta;                // First stage, read only by pin_sync
   logic [PORT_W-1:0] pin_sync;                // Synchronised pin levels
   logic [CN_W-1:0] cn_meta;                   // First stage, read only by cn_sync
   logic [CN_W-1:0] cn_sync;                   // Synchronised CN levels
   logic [CN_W-1:0] cn_prev;                   // Previous CN sample
   logic cn_req;                               // Registered change pulse
   logic next_cn_req;
   logic [PORT_W-1:0] pin_out;                 // Registered pin data
   logic [PORT_W-1:0] pin_oe;                  // Registered pin enables
   logic [PORT_W-1:0] per_in;                  // Registered peripheral input
   logic [PORT_W-1:0] next_pin_out;
   logic [PORT_W-1:0] next_pin_oe;
   logic [PORT_W-1:0] next_per_in;

   // ****************************************************************
   // Derived views
   // ****************************************************************
   logic [GPCN_AN_MAX-1:0] an_cfg;             // Full analog config word
   logic [PORT_W-1:0] pin_analog;              // Pins currently analog
   logic [PORT_W-1:0] pin_level;               // Value of pin_level_reg
   logic [CN_W-1:0] cn_en;                     // Full CN enable word

   assign an_cfg = {analog_pin_config_hi, analog_pin_config_lo};
   assign cn_en = {change_irq_enable_hi, change_irq_enable_lo};

   // Analog function only where the pin has one and its config bit is zero
   assign pin_analog = ~an_cfg[AN_BASE +: PORT_W] & AN_MASK[PORT_W-1:0];
   // Analog pins read low, absent pins read zero
   assign pin_level = pin_sync & ~pin_analog & IMPL;

   // ****************************************************************
   // Register write and read
   // ****************************************************************
   // Next register values from the write strobe
   always_comb begin
      next_dir = pin_direction_reg;
      next_lat = output_latch_reg;
      next_odc = open_drain_select_reg;
      next_anlo = analog_pin_config_lo;
      next_anhi = analog_pin_config_hi;
      next_cnelo = change_irq_enable_lo;
      next_cnehi = change_irq_enable_hi;
      next_pulo = weak_pullup_enable_lo;
      next_puhi = weak_pullup_enable_hi;
      if (wr_i) begin
         unique case (sel_i)
            GPCN_SEL_DIR: next_dir = wdata_i[PORT_W-1:0] & IMPL;
            GPCN_SEL_LAT: next_lat = wdata_i[PORT_W-1:0] & IMPL;
            GPCN_SEL_LVL: next_lat = wdata_i[PORT_W-1:0] & IMPL;
            GPCN_SEL_ODC: next_odc = wdata_i[PORT_W-1:0] & IMPL;
            GPCN_SEL_ANLO: next_anlo = wdata_i;
            GPCN_SEL_ANHI: next_anhi = wdata_i;
            GPCN_SEL_CNELO: next_cnelo = wdata_i;
            GPCN_SEL_CNEHI: next_cnehi = wdata_i[CNH-1:0];
            GPCN_SEL_PULO: next_pulo = wdata_i;
            GPCN_SEL_PUHI: next_puhi = wdata_i[CNH-1:0];
            default: begin
               // Unknown select codes are ignored
            end
         endcase
      end
   end

   // Read data, latched on the read strobe and held until the next read
   always_comb begin
      next_rdata = rdata;
      if (rd_i) begin
         next_rdata = 16'h0000;
         unique case (sel_i)
            GPCN_SEL_DIR: next_rdata[PORT_W-1:0] = pin_direction_reg;
            GPCN_SEL_LAT: next_rdata[PORT_W-1:0] = output_latch_reg;
            GPCN_SEL_LVL: next_rdata[PORT_W-1:0] = pin_level;
            GPCN_SEL_ODC: next_rdata[PORT_W-1:0] = open_drain_select_reg;
            GPCN_SEL_ANLO: next_rdata = analog_pin_config_lo;
            GPCN_SEL_ANHI: next_rdata = analog_pin_config_hi;
            GPCN_SEL_CNELO: next_rdata = change_irq_enable_lo;
            GPCN_SEL_CNEHI: next_rdata[CNH-1:0] = change_irq_enable_hi;
            GPCN_SEL_PULO: next_rdata = weak_pullup_enable_lo;
            GPCN_SEL_PUHI: next_rdata[CNH-1:0] = weak_pullup_enable_hi;
            default: begin
               // Unknown select codes read as zero
            end
         endcase
      end
   end

   // Register file; direction resets to input on every present pin (absent pins read zero), analog to all analog
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_direction_reg <= GPCN_DIR_RST[PORT_W-1:0] & IMPL;
         output_latch_reg <= GPCN_LAT_RST[PORT_W-1:0];
         open_drain_select_reg <= GPCN_ODC_RST[PORT_W-1:0];
         analog_pin_config_lo <= GPCN_AN_RST;
         analog_pin_config_hi <= GPCN_AN_RST;
         change_irq_enable_lo <= GPCN_CNE_RST;
         change_irq_enable_hi <= GPCN_CNE_RST[CNH-1:0];
         weak_pullup_enable_lo <= GPCN_PU_RST;
         weak_pullup_enable_hi <= GPCN_PU_RST[CNH-1:0];
         rdata <= 16'h0000;
      end else if (ce_i) begin
         pin_direction_reg <= next_dir;
         output_latch_reg <= next_lat;
         open_drain_select_reg <= next_odc;
         analog_pin_config_lo <= next_anlo;
         analog_pin_config_hi <= next_anhi;
         change_irq_enable_lo <= next_cnelo;
         change_irq_enable_hi <= next_cnehi;
         weak_pullup_enable_lo <= next_pulo;
         weak_pullup_enable_hi <= next_puhi;
         rdata <= next_rdata;
      end
   end

   // ****************************************************************
   // Pin ownership and drivers
   // ****************************************************************
   // Per-pin multiplexing between peripheral and port
   for (genvar i = 0; i < PORT_W; i++) begin : g_pin
      logic per_owns;                          // Peripheral holds the pin
      logic port_drives;                       // Port output driver on
      assign per_owns = per_en_i[i] & per_drv_i[i];
      assign port_drives = IMPL[i] & ~pin_direction_reg[i] & ~per_owns;
      always_comb begin
         if (per_owns) begin
            next_pin_out[i] = per_out_i[i];
            next_pin_oe[i] = 1'b1;
         end else if (open_drain_select_reg[i]) begin
            // Open drain pulls low only; an external resistor makes the high
            next_pin_out[i] = 1'b0;
            next_pin_oe[i] = port_drives & ~output_latch_reg[i];
         end else begin
            next_pin_out[i] = output_latch_reg[i];
            next_pin_oe[i] = port_drives;
         end
         // A pin the port drives is hidden from the peripheral input
         next_per_in[i] = pin_sync[i] & ~port_drives;
      end
   end

   // Registered pin outputs; one cycle of latency traded for clean outputs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_out <= '0;
         pin_oe <= '0;
         per_in <= '0;
      end else if (ce_i) begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         per_in <= next_per_in;
      end
   end

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   // Two flops on every pin before any clocked logic looks at it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_meta <= '0;
         pin_sync <= '0;
         cn_meta <= '0;
         cn_sync <= '0;
      end else if (ce_i) begin
         pin_meta <= pin_in_i;
         pin_sync <= pin_meta;
         cn_meta <= cn_pin_i;
         cn_sync <= cn_meta;
      end
   end

   // ****************************************************************
   // Change notification
   // ****************************************************************
   // Any enabled input whose level differs from the last sample
   always_comb begin
      next_cn_req = |((cn_sync ^ cn_prev) & cn_en);
   end

   // Previous sample follows the synced level every enabled cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cn_prev <= '0;
         cn_req <= 1'b0;
      end else if (ce_i) begin
         cn_prev <= cn_sync;
         cn_req <= next_cn_req;
      end
   end

   // In Sleep no clock runs, so the raw pins are compared with the last
   // sample without flops. Glitches may wake the core; that is intended.
   assign cn_wake_o = sleep_i & (|((cn_pin_i ^ cn_prev) & cn_en));

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign rdata_o = rdata;
   assign pin_out_o = pin_out;
   assign pin_oe_o = pin_oe;
   assign per_in_o = per_in;
   assign an_mode_o = ~an_cfg;
   assign pullup_en_o = {weak_pullup_enable_hi, weak_pullup_enable_lo};
   assign cn_req_o = cn_req;

endmodule : gpcn_port

/* File: testbench/gpcn_port_asserts.sv */
`timescale 1ns/1ps
// ****
// Port and change-notify checks
// ****
module gpcn_port_asserts
   import gpcn_pkg::*;
#(
   parameter int PORT_W = 16,                    // Pins in the port
   parameter logic [15:0] IMPL_MASK = 16'hFFFF,  // Pins present
   parameter logic [15:0] AN_MASK = 16'h00FF,    // Pins with analog function
   parameter int CN_W = 30                       // Change-notify inputs
) (
   input wire logic clk_i,                       // Instruction clock
   input wire logic rst_i,                       // Async reset
   input wire logic ce_i,                        // Clock enable
   input wire logic wr_i,                        // Write strobe
   input wire logic rd_i,                        // Read strobe
   input wire logic [3:0] sel_i,                 // Register select
   input wire logic [15:0] wdata_i,              // Write data
   input wire logic [15:0] rdata_o,              // Read data
   input wire logic [PORT_W-1:0] pin_out_o,      // Pin drive data
   input wire logic [PORT_W-1:0] pin_oe_o,       // Pin drive enables
   input wire logic [PORT_W-1:0] per_en_i,       // Peripheral enabled
   input wire logic [PORT_W-1:0] per_drv_i,      // Peripheral driving
   input wire logic [PORT_W-1:0] per_out_i,      // Peripheral data
   input wire logic [PORT_W-1:0] per_in_o,       // Level to peripheral
   input wire logic [GPCN_AN_MAX-1:0] an_mode_o, // Analog mode
   input wire logic [CN_W-1:0] cn_pin_i,         // Change-notify pins
   input wire logic cn_req_o                     // Change request
);
   logic [PORT_W-1:0] own_q, next_own_q;         // Peripheral ownership, aligned with the pin flops
   logic [15:0] lat_m, next_lat_m;               // Expected latch
   logic [15:0] odc_m, next_odc_m;               // Expected open-drain selects
   logic [CN_W-1:0] cne_m, next_cne_m;           // Expected change enables
   logic dir_seen, next_dir_seen;                // Direction written since reset
   logic an_seen, next_an_seen;                  // Analog config written since reset
   logic [PORT_W-1:0] port_drv;                  // Pins the port itself drives
   assign port_drv = pin_oe_o & ~own_q;
   // Shadow state moves only in enabled cycles, so a frozen clock enable freezes it too
   always_comb begin
      next_own_q = own_q;
      next_lat_m = lat_m;
      next_odc_m = odc_m;
      next_cne_m = cne_m;
      next_dir_seen = dir_seen;
      next_an_seen = an_seen;
      if (ce_i) begin
         next_own_q = per_en_i & per_drv_i & IMPL_MASK;
         if (wr_i) begin
            case (sel_i)
               GPCN_SEL_LAT, GPCN_SEL_LVL: next_lat_m = wdata_i & IMPL_MASK;
               GPCN_SEL_ODC: next_odc_m = wdata_i;
               GPCN_SEL_DIR: next_dir_seen = 1'b1;
               GPCN_SEL_ANLO, GPCN_SEL_ANHI: next_an_seen = 1'b1;
               GPCN_SEL_CNELO: next_cne_m[15:0] = wdata_i;
               GPCN_SEL_CNEHI: next_cne_m[CN_W-1:16] = wdata_i[CN_W-17:0];
               default: ;
            endcase
         end
      end
   end
   // Register the shadow state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         own_q <= '0;
         lat_m <= 16'h0000;
         odc_m <= 16'h0000;
         cne_m <= '0;
         dir_seen <= 1'b0;
         an_seen <= 1'b0;
      end else begin
         own_q <= next_own_q;
         lat_m <= next_lat_m;
         odc_m <= next_odc_m;
         cne_m <= next_cne_m;
         dir_seen <= next_dir_seen;
         an_seen <= next_an_seen;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_dir_wr;
      ce_i && wr_i && sel_i == GPCN_SEL_DIR ##1 ce_i && !(wr_i && sel_i == GPCN_SEL_DIR);
   endsequence
   sequence s_cn_edge;
      ce_i && (((cn_pin_i ^ $past(cn_pin_i)) & cne_m) != '0) ##1 ce_i [*4];
   endsequence
   property p_periph_own;
      $past(ce_i) |-> (pin_oe_o & own_q) == own_q && (pin_out_o & own_q) == ($past(per_out_i) & own_q);
   endproperty
   property p_no_loop;
      (per_in_o & port_drv & $past(port_drv) & $past(port_drv, 2)) == '0;
   endproperty
   property p_dir_input;
      s_dir_wr |=> (pin_oe_o & $past(wdata_i, 2) & ~own_q) == '0;
   endproperty
   property p_dir_reset;
      !dir_seen |-> port_drv == '0;
   endproperty
   property p_lat_read;
      ce_i && rd_i && sel_i == GPCN_SEL_LAT |=> rdata_o == $past(lat_m);
   endproperty
   // Codes 0 to 2 are direction, latch and level
   property p_unimpl;
      ce_i && rd_i && sel_i < 4'h3 |=> (rdata_o & ~IMPL_MASK) == 16'h0000;
   endproperty
   property p_odc;
      $past(ce_i) |-> (pin_out_o & $past(odc_m) & ~own_q) == '0;
   endproperty
   property p_an_reset;
      !an_seen |-> an_mode_o == '1;
   endproperty
   property p_an_read;
      ce_i && rd_i && sel_i == GPCN_SEL_LVL |=> (rdata_o & $past(an_mode_o[15:0]) & AN_MASK) == 16'h0000;
   endproperty
   // The sync depth lets the pulse land on any of the last four samples
   property p_cn_req;
      s_cn_edge |-> cn_req_o || $past(cn_req_o) || $past(cn_req_o, 2) || $past(cn_req_o, 3);
   endproperty
   a_periph_own: assert property (p_periph_own) else $error("peripheral lost its pin");
   a_no_loop: assert property (p_no_loop) else $error("port output reached peripheral");
   a_dir_input: assert property (p_dir_input) else $error("input pin driven");
   a_dir_reset: assert property (p_dir_reset) else $error("pin driven after reset");
   a_lat_read: assert property (p_lat_read) else $error("latch read wrong");
   a_unimpl: assert property (p_unimpl) else $error("absent bit read nonzero");
   a_odc: assert property (p_odc) else $error("open-drain pin driven high");
   a_an_reset: assert property (p_an_reset) else $error("analog mode not default");
   a_an_read: assert property (p_an_read) else $error("analog pin read high");
   a_cn_req: assert property (p_cn_req) else $error("change request missing");
endmodule : gpcn_port_asserts

bind gpcn_port gpcn_port_asserts #(.PORT_W(PORT_W), .IMPL_MASK(IMPL_MASK), .AN_MASK(AN_MASK), .CN_W(CN_W))
   gpcn_port_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wr_i(wr_i), .rd_i(rd_i), .sel_i(sel_i),
   .wdata_i(wdata_i), .rdata_o(rdata_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .per_en_i(per_en_i),
   .per_drv_i(per_drv_i), .per_out_i(per_out_i), .per_in_o(per_in_o), .an_mode_o(an_mode_o),
   .cn_pin_i(cn_pin_i), .cn_req_o(cn_req_o));

/* File: testbench/gpcn_pin_model.sv */
`timescale 1ns/1ps
// ****
// Board side of the port pins
// ****
module gpcn_pin_model #(
   parameter int PORT_W = 16                  // Pins modelled
) (
   input wire logic clk_i,                    // Clock for the floating pattern
   input wire logic [PORT_W-1:0] pin_out_i,   // Device drive data
   input wire logic [PORT_W-1:0] pin_oe_i,    // Device drive enables
   input wire logic [PORT_W-1:0] ext_en_i,    // Board drivers active
   input wire logic [PORT_W-1:0] ext_val_i,   // Board drive data
   output logic [PORT_W-1:0] pin_o            // Resolved levels
);
   logic flt = 1'b0;                          // Floating pins wander every cycle
   always @(posedge clk_i) flt <= ~flt;
   // Board drives through series resistors, so the device wins; nobody driving gives no stable value
   always_comb begin
      pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_val_i) | (~pin_oe_i & ~ext_en_i & {PORT_W{flt}});
   end
endmodule : gpcn_pin_model

/* File: testbench/gpio_port_change_notify_bench.sv */
`timescale 1ns/1ps
// ****
// Self-checking bench
// ****
module gpio_port_change_notify_bench import gpcn_pkg::*;;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, sleep_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [3:0] sel_i = 4'h0;                  // Register select
   logic [15:0] wdata_i = 16'h0000, rdata_o;  // Register data
   logic [15:0] pin_in_i, pin_out_o, pin_oe_o, per_in_o;
   logic [15:0] per_en_i = 16'h0000, per_drv_i = 16'h0000, per_out_i = 16'h0000;
   logic [15:0] ext_en = 16'hFFFF, ext_val = 16'h5A5A;  // Board drivers
   logic [31:0] an_mode_o;
   logic [29:0] cn_pin_i = 30'h0, pullup_en_o;
   logic cn_req_o, cn_wake_o;
   int fails = 0, compares = 0;
   initial forever #20 clk_i = ~clk_i;
   // Top pin left absent to reach the unimplemented-bit path
   gpcn_port #(.IMPL_MASK(16'h7FFF)) gpcn_port_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .sleep_i(sleep_i),
      .wr_i(wr_i), .rd_i(rd_i), .sel_i(sel_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .pin_in_i(pin_in_i),
      .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .per_en_i(per_en_i), .per_drv_i(per_drv_i),
      .per_out_i(per_out_i), .per_in_o(per_in_o), .an_mode_o(an_mode_o), .cn_pin_i(cn_pin_i),
      .pullup_en_o(pullup_en_o), .cn_req_o(cn_req_o), .cn_wake_o(cn_wake_o));
   gpcn_pin_model gpcn_pin_model_i (.clk_i(clk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pin_in_i));
   task automatic report_and_stop;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [3:0] s, input logic [15:0] v);
      @(negedge clk_i);
      wr_i = 1'b1;
      sel_i = s;
      wdata_i = v;
      @(negedge clk_i);
      wr_i = 1'b0;
   endtask : wr
   // Starting on a fresh falling edge leaves a spare cycle after any write
   task automatic rdc(input string what, input logic [3:0] s, input logic [15:0] exp);
      @(negedge clk_i);
      rd_i = 1'b1;
      sel_i = s;
      @(negedge clk_i);
      rd_i = 1'b0;
      chk(what, exp, rdata_o);
   endtask : rdc
   // Counts change pulses over a bounded window
   task automatic pulses(input logic [31:0] exp);
      int c;
      c = 0;
      repeat (8) begin
         @(negedge clk_i);
         if (cn_req_o === 1'b1) c++;
      end
      chk("change pulses", exp, 32'(c));
   endtask : pulses
   task automatic t_reset;
      rdc("direction", GPCN_SEL_DIR, 16'h7FFF);
      rdc("analog lo", GPCN_SEL_ANLO, 16'h0000);
      chk("analog mode", 32'hFFFFFFFF, an_mode_o);
      chk("drive enables", 32'h0, pin_oe_o);
   endtask : t_reset
   task automatic t_latch;
      wr(GPCN_SEL_ANLO, 16'hFFFF);
      wr(GPCN_SEL_LVL, 16'h1234);
      rdc("latch via level", GPCN_SEL_LAT, 16'h1234);
      wr(GPCN_SEL_LAT, 16'hA5C3);
      rdc("latch", GPCN_SEL_LAT, 16'h25C3);
      wr(GPCN_SEL_DIR, 16'hFF00);
      repeat (3) @(negedge clk_i);
      chk("drive enables", 32'h00FF, pin_oe_o);
      rdc("pin level", GPCN_SEL_LVL, 16'h5AC3);
      wr(GPCN_SEL_DIR, 16'hFFFF);
      wr(GPCN_SEL_ANLO, 16'h0000);
      repeat (3) @(negedge clk_i);
      rdc("analog level", GPCN_SEL_LVL, 16'h5A00);
      wr(GPCN_SEL_ANLO, 16'hFFFF);
   endtask : t_latch
   task automatic t_odc;
      wr(GPCN_SEL_DIR, 16'h0000);
      wr(GPCN_SEL_LAT, 16'h0001);
      wr(GPCN_SEL_ODC, 16'h0003);
      @(negedge clk_i);
      chk("open-drain enables", 32'h2, pin_oe_o & 16'h0003);
      chk("open-drain data", 32'h0, pin_out_o & 16'h0003);
      rdc("open-drain selects", GPCN_SEL_ODC, 16'h0003);
      wr(GPCN_SEL_ODC, 16'h0000);
   endtask : t_odc
   task automatic t_periph;
      @(negedge clk_i);
      per_en_i = 16'h0010;
      per_drv_i = 16'h0010;
      per_out_i = 16'h0010;
      repeat (3) @(negedge clk_i);
      chk("owned pin data", 32'h0010, pin_out_o & 16'h0010);
      rdc("shared pin level", GPCN_SEL_LVL, 16'h0011);
      per_drv_i = 16'h0000;
      repeat (4) @(negedge clk_i);
      chk("idle peripheral pin", 32'h00100000, {pin_oe_o & 16'h0010, pin_out_o & 16'h0010});
      chk("peripheral input", 32'h0, per_in_o);
      per_en_i = 16'h0000;
   endtask : t_periph
   task automatic t_cn;
      wr(GPCN_SEL_PULO, 16'hFFFF);
      wr(GPCN_SEL_PUHI, 16'hFFFF);
      chk("pull-ups", 32'h3FFFFFFF, pullup_en_o);
      rdc("pull-up hi", GPCN_SEL_PUHI, 16'h3FFF);
      // Change input 5 stands for a pin used as a digital output: no pull-up there
      wr(GPCN_SEL_PULO, 16'hFFDF);
      chk("pull-ups off on output", 32'h3FFFFFDF, pullup_en_o);
      wr(GPCN_SEL_CNELO, 16'h0001);
      wr(GPCN_SEL_CNEHI, 16'h2000);
      rdc("change enables hi", GPCN_SEL_CNEHI, 16'h2000);
      cn_pin_i[5] = 1'b1;
      pulses(32'd0);
      cn_pin_i[0] = 1'b1;
      pulses(32'd1);
      cn_pin_i[29] = 1'b1;
      pulses(32'd1);
      sleep_i = 1'b1;
      ce_i = 1'b0;
      cn_pin_i[0] = 1'b0;
      #1 chk("sleep wake", 32'h1, cn_wake_o);
      @(negedge clk_i);
      ce_i = 1'b1;
      sleep_i = 1'b0;
   endtask : t_cn
   initial begin
      repeat (5000) @(posedge clk_i);
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(negedge clk_i);
      rst_i = 1'b0;
      t_reset();
      t_latch();
      t_odc();
      t_periph();
      t_cn();
      report_and_stop();
   end
endmodule : gpio_port_change_notify_bench
